// ==== verilog/omx_defs.svh ====
// constants of the or/move/load instruction executor: register offsets,
// field positions, opcode patterns and reset values.
// assumes inclusion by the executor only.
//
// Behaviour
// [RULE1] literal OR into accumulator, one cycle
// [RULE2] accumulator OR file register, one cycle
// [RULE3] destination bit picks accumulator or file register
// [RULE4] access bit picks access bank or bank
// [RULE5] extended mode low addresses use pointer indexing
// [RULE6] OR and move update only negative, zero
// [RULE7] pointer load: high part first, low second
// [RULE8] pointer load leaves all flags unchanged
// [RULE9] register move copies file register to destination
// [RULE10] register move reaches whole 256-byte bank
// [RULE11] two-word move spans 4096-byte space, two cycles
// [RULE12] software never moves into program counter, stack
// [RULE13] two-word move treats accumulator as location
// [RULE14] negative is bit 7, zero when all clear
// [RULE15] move reads first cycle, writes second, no dummy
`ifndef OMX_DEFS_SVH
`define OMX_DEFS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define OMX_OFF_INSTR  8'h00
`define OMX_OFF_ACC    8'h04
`define OMX_OFF_STAT   8'h08
`define OMX_OFF_BANK   8'h0C
`define OMX_OFF_CTRL   8'h10
`define OMX_OFF_PTR0   8'h14
`define OMX_OFF_LAST   8'h1C

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define OMX_ST_Z       0
`define OMX_ST_N       1
`define OMX_ST_BUSY    2
`define OMX_ST_WAIT2   3
`define OMX_CTRL_EXT   0

// ------------------------------------------------------------------
// opcode patterns, access bank split, accumulator location
// ------------------------------------------------------------------
`define OMX_OP_ORLIT   8'h09
`define OMX_OP_ORREG   6'h04
`define OMX_OP_MOVREG  6'h14
`define OMX_OP_LDPTR   10'h3B8
`define OMX_OP_LDPTR2  8'hF0
`define OMX_OP_MVFF    4'hC
`define OMX_OP_SECOND  4'hF
`define OMX_ACC_SPLIT  8'h60
`define OMX_ACC_HIGH   4'hF
`define OMX_ACC_ADDR   12'hFE8
`define OMX_Q_LAST     2'h3

// ------------------------------------------------------------------
// reset values and responses
// ------------------------------------------------------------------
`define OMX_RST_BYTE   8'h00
`define OMX_RST_PTR    12'h000
`define OMX_RESP_OKAY  2'h0
`define OMX_RESP_SLV   2'h2

`endif

// ==== verilog/omx_pkg.sv ====
// types shared by the executor: engine phases, memory request, state.
// assumes omx_defs.svh is on the include path.
`default_nettype none
package omx_pkg;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_run, st_second} omx_phase_t;

  // request to the data memory, one access per pulse
  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } omx_mem_t;

  // whole state of the executor
  typedef struct packed {
    omx_phase_t        st;
    logic [1:0]        q;
    logic              second;
    logic [15:0]       instr;
    logic [15:0]       first;
    logic [7:0]        data;
    logic [7:0]        acc;
    logic              zf;
    logic              nf;
    logic [3:0]        bank;
    logic              ext;
    logic [2:0][11:0]  ptr;
    omx_mem_t          mem;
    logic              awready;
    logic              wready;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic              wstrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } omx_state_t;
endpackage
`default_nettype wire

// ==== verilog/omx_exec.sv ====
// executor for literal/register OR, register move, pointer load and
// the two-word move, fed one instruction word per register write.
// assumes a data memory that answers a read one cycle after rd.
`include "omx_defs.svh"
`default_nettype none
module omx_exec (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // axi4-lite write side
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read side
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // data memory
  output var  omx_pkg::omx_mem_t mem_req,
  input  wire logic [7:0]        mem_rdata
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // register index from byte address, 4'hF when unmapped
  function automatic logic [3:0] reg_idx(input logic [7:0] a);
    if (a[1:0] != 2'h0 || a > `OMX_OFF_LAST)
      reg_idx = 4'hF;
    else
      reg_idx = {2'h0, a[3:2]} + {3'h0, a[4]} * 4'h4;
  endfunction

  function automatic logic is_ldptr(input logic [15:0] w);
    is_ldptr = (w[15:6] == `OMX_OP_LDPTR);
  endfunction

  function automatic logic is_mvff(input logic [15:0] w);
    is_mvff = (w[15:12] == `OMX_OP_MVFF);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  omx_pkg::omx_state_t s;      // registered state
  omx_pkg::omx_state_t n;      // next state
  logic        op_orlit;       // first-word decodes
  logic        op_orreg;
  logic        op_mov;
  logic        op_byte;        // orreg or mov
  logic [7:0]  res;            // alu result of the current word
  logic [11:0] eff;            // effective file address
  logic [3:0]  widx;           // write register index
  logic [3:0]  ridx;           // read register index
  logic        ph0;            // engine in decode phase
  logic        ph3;            // engine in write phase

  assign op_orlit = (s.instr[15:8] == `OMX_OP_ORLIT);
  assign op_orreg = (s.instr[15:10] == `OMX_OP_ORREG);
  assign op_mov   = (s.instr[15:10] == `OMX_OP_MOVREG);
  assign op_byte  = (op_orreg || op_mov) && !s.second;
  assign widx     = reg_idx(s.awaddr);
  assign ridx     = reg_idx(s_axi_araddr);
  assign ph0      = (s.st == omx_pkg::st_run) && (s.q == 2'h0);
  assign ph3      = (s.st == omx_pkg::st_run) && (s.q == `OMX_Q_LAST);

  // ----------------------------------------------------------------
  // address and result
  // ----------------------------------------------------------------
  always_comb begin
    // indexed mode wins over the plain access bank
    if (!s.instr[8] && s.ext && s.instr[7:0] < `OMX_ACC_SPLIT)
      eff = s.ptr[2] + {4'h0, s.instr[7:0]};          // RULE5
    else if (!s.instr[8])
      eff = (s.instr[7:0] < `OMX_ACC_SPLIT) ?
            {4'h0, s.instr[7:0]} :
            {`OMX_ACC_HIGH, s.instr[7:0]};            // RULE4
    else
      eff = {s.bank, s.instr[7:0]};                   // RULE4 RULE10
    if (op_orlit)
      res = s.acc | s.instr[7:0];                     // RULE1
    else if (op_orreg)
      res = s.acc | s.data;                           // RULE2
    else
      res = s.data;                                   // RULE9
  end

  // ----------------------------------------------------------------
  // next state: bus slave, then the instruction engine
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.mem.rd = 1'b0;
    n.mem.wr = 1'b0;
    // address and data may arrive in either order
    if (s_axi_awvalid && s.awready) begin
      n.awaddr  = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      n.wdata  = s_axi_wdata;
      n.wstrb0 = s_axi_wstrb[0];
      n.wready = 1'b0;
    end
    // both held: perform the write; all but ctrl refused while running
    if (!s.awready && !s.wready && !s.bvalid) begin
      n.bvalid = 1'b1;
      n.bresp  = `OMX_RESP_OKAY;
      if (widx > 4'h7)
        n.bresp = `OMX_RESP_SLV;
      else if (s.st == omx_pkg::st_run && widx != 4'h4)
        n.bresp = `OMX_RESP_SLV;
      else if (s.wstrb0) begin
        unique case (widx)
          4'h0: begin
            n.instr = s.wdata[15:0];
            n.st    = omx_pkg::st_run;
            n.q     = 2'h0;
            n.second = (s.st == omx_pkg::st_second);
          end
          4'h1: n.acc  = s.wdata[7:0];
          4'h2: begin
            n.zf = s.wdata[`OMX_ST_Z];
            n.nf = s.wdata[`OMX_ST_N];
          end
          4'h3: n.bank = s.wdata[3:0];
          4'h4: n.ext  = s.wdata[`OMX_CTRL_EXT];
          default: n.ptr[widx[1:0] - 2'h1] = s.wdata[11:0];
        endcase
      end
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = (ridx > 4'h7) ? `OMX_RESP_SLV : `OMX_RESP_OKAY;
      unique case (ridx)
        4'h0: n.rdata = {16'h0000, s.instr};
        4'h1: n.rdata = {24'h00_0000, s.acc};
        4'h2: n.rdata = {28'h000_0000, s.st == omx_pkg::st_second,
                         s.st == omx_pkg::st_run, s.nf, s.zf};
        4'h3: n.rdata = {28'h000_0000, s.bank};
        4'h4: n.rdata = {31'h0000_0000, s.ext};
        4'h5, 4'h6, 4'h7:
              n.rdata = {20'h0_0000, s.ptr[ridx[1:0] - 2'h1]};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
    // engine: one instruction cycle is four clocks, q1..q4
    if (s.st == omx_pkg::st_run) begin
      n.q = s.q + 2'h1;
      unique case (s.q)
        2'h0: begin
          // decode: raise the read for the source
          if (op_byte) begin
            n.mem.addr = eff;
            n.mem.rd   = 1'b1;
          end else if (is_mvff(s.instr) && !s.second &&
                       s.instr[11:0] != `OMX_ACC_ADDR) begin
            n.mem.addr = s.instr[11:0];                 // RULE11
            n.mem.rd   = 1'b1;                          // RULE15
          end
        end
        2'h1: ;
        2'h2: begin
          // source byte; accumulator counts as a location
          if (!s.second)
            n.data = (is_mvff(s.instr) &&
                      s.instr[11:0] == `OMX_ACC_ADDR) ?
                     s.acc : mem_rdata;                 // RULE13
        end
        default: begin
          // write phase
          n.st     = omx_pkg::st_idle;
          n.second = 1'b0;
          if (!s.second) begin
            n.first = s.instr;
            if (op_orlit || op_byte) begin
              n.nf = res[7];                            // RULE6 RULE14
              n.zf = (res == 8'h00);                    // RULE14
              if (op_byte && s.instr[9]) begin
                n.mem.addr  = eff;                      // RULE3
                n.mem.wdata = res;
                n.mem.wr    = 1'b1;
              end else
                n.acc = res;                            // RULE1 RULE3
            end else if (is_ldptr(s.instr)) begin
              if (s.instr[5:4] != 2'h3)
                n.ptr[s.instr[5:4]][11:8] = s.instr[3:0]; // RULE7
              n.st = omx_pkg::st_second;
            end else if (is_mvff(s.instr))
              n.st = omx_pkg::st_second;                // RULE11
          end else if (s.instr[15:12] == `OMX_OP_SECOND) begin
            if (is_ldptr(s.first) && s.instr[11:8] == 4'h0 &&
                s.first[5:4] != 2'h3)
              n.ptr[s.first[5:4]][7:0] = s.instr[7:0];  // RULE7 RULE8
            else if (is_mvff(s.first)) begin
              if (s.instr[11:0] == `OMX_ACC_ADDR)
                n.acc = s.data;                         // RULE13
              else begin
                n.mem.addr  = s.instr[11:0];            // RULE15
                n.mem.wdata = s.data;
                n.mem.wr    = 1'b1;                     // RULE11 RULE12
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register; ready lines high so the bus can start at once
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s         <= '0;
      s.st      <= omx_pkg::st_idle;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state flops
  // ----------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign mem_req       = s.mem;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_orlit_acc: assert property ( // RULE1
    ph3 && op_orlit && !s.second |=>
      s.acc == ($past(s.acc) | $past(s.instr[7:0])) &&
      s.st == omx_pkg::st_idle)
    else $error("literal or result wrong");

  chk_orreg_acc: assert property ( // RULE2
    ph3 && op_orreg && !s.second && !s.instr[9] |=>
      s.acc == ($past(s.acc) | $past(s.data)))
    else $error("register or result wrong");

  chk_dest_file: assert property ( // RULE3
    ph3 && op_byte && s.instr[9] |=>
      s.mem.wr && s.mem.wdata == $past(res) && $stable(s.acc))
    else $error("file destination not written");

  chk_bank_addr: assert property ( // RULE4
    ph0 && op_byte && s.instr[8] |=>
      s.mem.rd && s.mem.addr == {$past(s.bank), $past(s.instr[7:0])})
    else $error("banked address wrong");

  chk_indexed_addr: assert property ( // RULE5
    ph0 && op_byte && !s.instr[8] && s.ext &&
    s.instr[7:0] <= 8'h5F |=>
      s.mem.addr == $past(s.ptr[2]) + {4'h0, $past(s.instr[7:0])})
    else $error("indexed address wrong");

  chk_flags_nz: assert property ( // RULE14
    ph3 && op_mov && !s.second |=>
      s.zf == ($past(s.data) == 8'h00) && s.nf == $past(s.data[7]))
    else $error("negative or zero flag wrong");

  chk_ptr_load: assert property ( // RULE7
    ph3 && s.second && is_ldptr(s.first) &&
    s.instr[15:8] == `OMX_OP_LDPTR2 && s.first[5:4] == 2'h1 |=>
      s.ptr[1][7:0] == $past(s.instr[7:0]) && $stable(s.zf) &&
      $stable(s.nf))
    else $error("pointer low byte not loaded");

  chk_mvff_noread: assert property ( // RULE15
    s.st == omx_pkg::st_run && s.second |=> !s.mem.rd)
    else $error("dummy read in second word");

  chk_mvff_write: assert property ( // RULE11
    ph3 && s.second && is_mvff(s.first) &&
    s.instr[15:12] == `OMX_OP_SECOND &&
    s.instr[11:0] != `OMX_ACC_ADDR |=>
      s.mem.wr && s.mem.addr == $past(s.instr[11:0]) &&
      s.mem.wdata == $past(s.data) && $stable(s.zf))
    else $error("two-word move write wrong");

  cov_orlit: cover property (ph3 && op_orlit);
  cov_ldptr: cover property (ph3 && s.second && is_ldptr(s.first));
  cov_mvff:  cover property (ph3 && s.second && is_mvff(s.first));
endmodule
`default_nettype wire

// ==== testbench/omx_mem_model.sv ====
// data memory partner of the executor: 4096 bytes, one-cycle reads.
// assumes the executor's clock and the omx_pkg request struct.
`default_nettype none
module omx_mem_model (
  // clock
  input  wire logic              clock,
  // request in, read byte out
  input  wire omx_pkg::omx_mem_t mem_req,
  output var  logic [7:0]        mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [4096];  // byte store, preset to a known pattern
  initial begin
    for (int i = 0; i < 4096; i++) begin
      ram[i] = 8'(i * 7 + 3);
    end
    mem_rdata = 8'h00;
  end
  // data stands in the cycle after a read; each later cycle without a read
  // inverts the byte, so a sample one cycle late never matches by luck
  always @(posedge clock) begin
    if (mem_req.rd) begin
      mem_rdata <= ram[mem_req.addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req.wr) begin
      ram[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench of the or/move/load executor over axi4-lite.
// assumes omx_pkg compiled first and the memory model beside it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clock, rst_b;
  logic [7:0]        awaddr, araddr, mem_rdata;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       wdata, rdata, seed, v32;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r2;
  omx_pkg::omx_mem_t mem_req;
  int                error_cnt, total_checks;
  // reference state kept by the bench
  logic [7:0]        acc, f, k, v, res;
  logic              en, ez, ext, d, a;
  logic [3:0]        bank;
  logic [1:0]        op;
  logic [11:0]       ptr [3];
  logic [11:0]       ad, src, dst;

  omx_exec dut (
    .clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_rdata(mem_rdata)
  );
  omx_mem_model u_mem (.clock(clock), .mem_req(mem_req),
                       .mem_rdata(mem_rdata));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] load_pointer_literal(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  // data address a byte instruction reaches
  function automatic logic [11:0] eff(input logic aa, input logic [7:0] ff);
    if (aa) return {bank, ff};
    if (ext && ff <= 8'h5F) return ptr[2] + {4'h0, ff};
    return (ff < 8'h60) ? {4'h0, ff} : {4'hF, ff};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string w);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, w, s, e);
    end
  endtask
  // one write; master holds each channel until its own ready
  task automatic axi_wr(input logic [7:0] ad8, input logic [31:0] dd,
                        input logic [1:0] er);
    int n;
    @(posedge clock);
    awaddr <= ad8;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    if (n == 40) begin
      error_cnt++;
      tally_and_finish();
    end
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask
  task automatic axi_rd(input logic [7:0] ad8, output logic [31:0] dd,
                        output logic [1:0] rr);
    int n;
    @(posedge clock);
    araddr <= ad8;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (n == 40) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic expect_reg(input logic [7:0] ad8, input logic [31:0] e,
                            input string w);
    logic [31:0] dd;
    logic [1:0]  rr;
    axi_rd(ad8, dd, rr);
    check(dd, e, w);
  endtask
  // issue one word, then poll busy under a bound
  task automatic run_instr(input logic [15:0] w);
    logic [31:0] st;
    logic [1:0]  rr;
    axi_wr(8'h00, {16'h0000, w}, 2'h0);
    st = 32'h0000_0004;
    for (int n = 0; n < 20 && st[2]; n++) axi_rd(8'h08, st, rr);
    if (st[2] !== 1'b0) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic chk_state(input logic w2);
    expect_reg(8'h04, {24'h0, acc}, "accumulator");
    expect_reg(8'h08, {28'h0, w2, 1'b0, en, ez}, "status");
  endtask

  // ------------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    rst_b = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    {error_cnt, total_checks} = '0;
    seed = 32'h08dc_657c;
    {acc, en, ez, ext, bank} = '0;
    ptr = '{default: 12'h000};
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    // reset values, unmapped and misaligned places
    for (int i = 0; i < 7; i++) expect_reg(8'(8'h04 + 4 * i), 0, "reset");
    axi_rd(8'h20, v32, r2);
    check({v32[29:0], r2}, 32'h0000_0002, "unmapped read");
    axi_wr(8'h02, 32'h0000_0001, 2'h2);
    $display("test reset_map done");
    // literal or corners, including a zero result
    axi_wr(8'h04, 32'h0000_009A, 2'h0);
    acc = 8'h9A;
    run_instr(16'h0935);
    {acc, en, ez} = {8'hBF, 2'b10};
    chk_state(1'b0);
    axi_wr(8'h04, 32'h0000_0000, 2'h0);
    run_instr(16'h0900);
    {acc, en, ez} = {8'h00, 2'b01};
    chk_state(1'b0);
    $display("test literal_or done");
    // pointer load into each of the three pointers
    for (int i = 0; i < 3; i++) begin
      seed = load_pointer_literal(seed);
      src = seed[11:0];
      run_instr({8'hEE, 2'b00, 2'(i), src[11:8]});
      expect_reg(8'(8'h14 + 4 * i), {20'h0, src[11:8], ptr[i][7:0]}, "hi");
      chk_state(1'b1);
      run_instr({8'hF0, src[7:0]});
      ptr[i] = src;
      expect_reg(8'(8'h14 + 4 * i), {20'h0, src}, "pointer");
      chk_state(1'b0);
    end
    $display("test pointer_load done");
    // random byte instructions over banks, access and indexed modes
    for (int i = 0; i < 60; i++) begin
      seed = load_pointer_literal(seed);
      {op, d, a, ext, bank} = seed[8:0];
      {f, k} = seed[24:9];
      if (i == 0) begin
        {op, d, a, ext, f} = {5'b10000, 8'h10};
        u_mem.ram[12'h010] = 8'h00;
      end
      if (op == 2'd3) op = 2'd2;
      if (eff(a, f) == 12'hFE8) f = f ^ 8'h01;
      ad = eff(a, f);
      axi_wr(8'h0C, {28'h0, bank}, 2'h0);
      axi_wr(8'h10, {31'h0, ext}, 2'h0);
      v = u_mem.ram[ad];
      res = (op == 2'd0) ? (acc | k) : (op == 2'd1) ? (acc | v) : v;
      case (op)
        2'd0: run_instr({8'h09, k});
        2'd1: run_instr({6'h04, d, a, f});
        default: run_instr({6'h14, d, a, f});
      endcase
      if (op == 2'd0 || !d) acc = res;
      {en, ez} = {res[7], res == 8'h00};
      chk_state(1'b0);
      check({24'h0, u_mem.ram[ad]}, {24'h0, (op != 0 && d) ? res : v},
            "file register");
    end
    axi_wr(8'h10, 32'h0000_0000, 2'h0);
    ext = 1'b0;
    $display("test byte_ops done");
    // two-word move, accumulator as source and as destination
    for (int i = 0; i < 10; i++) begin
      seed = load_pointer_literal(seed);
      src = (i == 0) ? 12'hFE8 : seed[11:0];
      dst = (i == 1) ? 12'hFE8 : {1'b0, seed[22:12]};
      v = (src == 12'hFE8) ? acc : u_mem.ram[src];
      run_instr({4'hC, src});
      chk_state(1'b1);
      run_instr({4'hF, dst});
      if (dst == 12'hFE8) acc = v;
      else check({24'h0, u_mem.ram[dst]}, {24'h0, v}, "move");
      chk_state(1'b0);
    end
    $display("test file_to_file done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
